//--- include/ssl_pkg.sv
// Functional notes
// - shift one bit per serial clock, msb first
// - load strobe rise copies word into latch
// - binary select codes zero to five; six, seven ignored
// - phase, modulus, doubler, halver, divider, current shadowed
// - shadowed settings apply on next latch zero write
// - divider select shadowed only when buffer bit set
// - whole part sixteen bits, range by prescaler
// - denominator 2..4095, numerator below denominator
// - feedback, numerator and denominator counters present
// - feedback divides by whole plus fraction
// - ten bit reference divider, ratio 1..1023
// - doubler and halver scale comparison rate
// - integer mode when numerator zero and function bit
// - probe selects lock, feedback or reference divider
// - two bits choose output power level
// - mute until lock keeps output off
// - chip enable low powers down, tristates pump
// - lock indicator high while locked
// - mute pin low silences output
package ssl_pkg;
  localparam int WORD_W = 32;
  localparam int NUM_LATCH = 6;
  localparam logic [2:0] SEL_R0 = 3'h0;
  localparam logic [2:0] SEL_R1 = 3'h1;
  localparam logic [2:0] SEL_R2 = 3'h2;
  localparam logic [2:0] SEL_R4 = 3'h4;
  localparam logic [31:0] LATCH_RST = 32'h0000_0000;
  // field positions
  localparam int INT_LSB = 15;
  localparam int PARTIAL_NUMERATOR_LSB = 3;
  localparam int PHASE_LSB = 15;
  localparam int MOD_LSB = 3;
  localparam int PRESC_BIT = 27;
  localparam int PROBE_LSB = 26;
  localparam int DBL_BIT = 25;
  localparam int HALF_BIT = 24;
  localparam int RDIV_LSB = 14;
  localparam int DBUF_BIT = 13;
  localparam int CP_LSB = 9;
  localparam int LDF_BIT = 8;
  localparam int PD_BIT = 5;
  localparam int CPTRI_BIT = 4;
  localparam int CRST_BIT = 3;
  localparam int DIVSEL_LSB = 20;
  localparam int MUTE_UNTIL_LOCK_BIT = 10;
  localparam int RFEN_BIT = 5;
  localparam int PWR_LSB = 3;
  // legal ranges
  localparam logic [15:0] INT_MIN_45 = 16'h0017;
  localparam logic [15:0] INT_MAX_45 = 16'h7FFF;
  localparam logic [15:0] INT_MIN_89 = 16'h004B;
  localparam logic [11:0] MOD_MIN = 12'h002;
  // probe codes
  localparam logic [2:0] PROBE_HIGH = 3'h1;
  localparam logic [2:0] PROBE_RDIV = 3'h3;
  localparam logic [2:0] PROBE_NDIV = 3'h4;
  localparam logic [2:0] PROBE_LOCK = 3'h6;
  // lock detector timing, in core clock cycles and comparisons
  localparam int LOCK_WIN_CYC = 4;
  localparam int LOCK_GOOD_CNT = 5;

  typedef enum logic {LK_UNLOCKED, LK_LOCKED} ssl_lock_t;

  // a zero ratio would stall a divider; treat it as one
  function automatic logic [16:0] ssl_safe_ratio(input logic [16:0] r);
    ssl_safe_ratio = (r == 17'h00000) ? 17'h00001 : r;
  endfunction
endpackage

//--- rtl/ssl_sync2.sv
`timescale 1ns/1ps
module ssl_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  generate
    if (W < 1) begin : g_bad
      $error("ssl_sync2 width must be at least one");
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

//--- rtl/ssl_pulse_div.sv
`timescale 1ns/1ps
module ssl_pulse_div #(
  parameter int CNT_W = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [CNT_W-1:0] ratio,
  output logic                  pulse_ff
);
  logic [CNT_W-1:0] cnt_ff;

  generate
    if (CNT_W < 2 || CNT_W > 17) begin : g_bad
      $error("ssl_pulse_div width out of range");
    end
  endgenerate

  // one output pulse per ratio input ticks
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff   <= '0;
      pulse_ff <= 1'b0;
    end else if (clear) begin
      cnt_ff   <= '0;
      pulse_ff <= 1'b0;
    end else if (tick) begin
      if (cnt_ff >= ratio - CNT_W'(1)) begin
        cnt_ff   <= '0;
        pulse_ff <= 1'b1;
      end else begin
        cnt_ff   <= cnt_ff + CNT_W'(1);
        pulse_ff <= 1'b0;
      end
    end else begin
      pulse_ff <= 1'b0;
    end
  end
endmodule

//--- rtl/ssl_config_top.sv
`timescale 1ns/1ps
module ssl_config_top #(
  parameter int LOCK_WIN  = ssl_pkg::LOCK_WIN_CYC,
  parameter int LOCK_GOOD = ssl_pkg::LOCK_GOOD_CNT
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        load_strobe,
  input  wire logic        chip_enable,
  input  wire logic        rf_output_mute_n,
  input  wire logic        ref_in,
  input  wire logic        rf_fb_in,
  output logic             lock_indicator,
  output logic             internal_probe_output,
  output logic             rf_out_enable,
  output logic [1:0]       rf_power_level,
  output logic [2:0]       out_div_sel,
  output logic [2:0]       cp_current,
  output logic [11:0]      phase_value,
  output logic             prescaler_89,
  output logic             cp_tristate,
  output logic             device_powered,
  output logic             integer_mode,
  output logic             cfg_range_err
);
  import ssl_pkg::*;

  generate
    if (LOCK_WIN < 1 || LOCK_WIN > 254 || LOCK_GOOD < 1 || LOCK_GOOD > 255) begin : g_bad
      $error("ssl_config_top lock parameters out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [6:0]  pins_q;
  logic        sclk_q;
  logic        sdat_q;
  logic        le_q;
  logic        ce_q;
  logic        mute_n_q;
  logic        ref_q;
  logic        fb_q;
  logic        sclk_d_ff;
  logic        le_d_ff;
  logic        ref_d_ff;
  logic        fb_d_ff;
  logic        sclk_rise;
  logic        le_rise;

  ssl_sync2 #(.W(7)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .d        ({serial_clk, serial_data, load_strobe, chip_enable, rf_output_mute_n, ref_in, rf_fb_in}),
    .q        (pins_q)
  );

  assign {sclk_q, sdat_q, le_q, ce_q, mute_n_q, ref_q, fb_q} = pins_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_ff <= 1'b0;
      le_d_ff   <= 1'b0;
      ref_d_ff  <= 1'b0;
      fb_d_ff   <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_q;
      le_d_ff   <= le_q;
      ref_d_ff  <= ref_q;
      fb_d_ff   <= fb_q;
    end
  end

  assign sclk_rise = sclk_q & ~sclk_d_ff;
  assign le_rise   = le_q & ~le_d_ff;

  // ----------------------------------------------------------------
  // serial input register and latches
  // ----------------------------------------------------------------
  logic [31:0] shift_ff;
  logic [31:0] latch_ff [0:NUM_LATCH-1];
  logic [NUM_LATCH-1:0] wr;
  logic        r0_wr;
  logic        dbuf_on;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift_ff <= LATCH_RST;
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[30:0], sdat_q};
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_LATCH; i++) begin
      wr[i] = le_rise && (shift_ff[2:0] == 3'(i));
    end
  end

  assign r0_wr   = wr[SEL_R0];
  assign dbuf_on = latch_ff[SEL_R2][DBUF_BIT];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_LATCH; i++) begin
        latch_ff[i] <= LATCH_RST;
      end
    end else begin
      for (int i = 0; i < NUM_LATCH; i++) begin
        if (wr[i]) begin
          latch_ff[i] <= shift_ff;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // shadow stage
  // ----------------------------------------------------------------
  logic [11:0] mod_eff_ff;
  logic        dbl_eff_ff;
  logic        half_eff_ff;
  logic [9:0]  rdiv_eff_ff;
  logic [2:0]  cp_eff_ff;
  logic [11:0] phase_eff_ff;
  logic [2:0]  div_sel_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_eff_ff <= 12'h000;
      mod_eff_ff   <= 12'h000;
      dbl_eff_ff   <= 1'b0;
      half_eff_ff  <= 1'b0;
      rdiv_eff_ff  <= 10'h000;
      cp_eff_ff    <= 3'h0;
    end else if (r0_wr) begin
      phase_eff_ff <= latch_ff[SEL_R1][PHASE_LSB +: 12];
      mod_eff_ff   <= latch_ff[SEL_R1][MOD_LSB +: 12];
      dbl_eff_ff   <= latch_ff[SEL_R2][DBL_BIT];
      half_eff_ff  <= latch_ff[SEL_R2][HALF_BIT];
      rdiv_eff_ff  <= latch_ff[SEL_R2][RDIV_LSB +: 10];
      cp_eff_ff    <= latch_ff[SEL_R2][CP_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_sel_ff <= 3'h0;
    end else if (wr[SEL_R4] && !dbuf_on) begin
      div_sel_ff <= shift_ff[DIVSEL_LSB +: 3];
    end else if (r0_wr && dbuf_on) begin
      div_sel_ff <= latch_ff[SEL_R4][DIVSEL_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // reference path
  // ----------------------------------------------------------------
  logic [15:0] int_val;
  logic [11:0] partial_numerator_val;
  logic        hold;
  logic        ref_tick;
  logic        rdiv_pulse;
  logic        half_tgl_ff;
  logic        ref_pfd;
  logic [16:0] rdiv_ratio;

  assign rdiv_ratio = ssl_safe_ratio({7'h00, rdiv_eff_ff});
  assign int_val  = latch_ff[SEL_R0][INT_LSB +: 16];
  assign partial_numerator_val = latch_ff[SEL_R0][PARTIAL_NUMERATOR_LSB +: 12];
  assign hold     = ~ce_q | latch_ff[SEL_R2][PD_BIT] | latch_ff[SEL_R2][CRST_BIT];

  // doubler counts both reference edges
  assign ref_tick = dbl_eff_ff ? (ref_q ^ ref_d_ff) : (ref_q & ~ref_d_ff);

  ssl_pulse_div #(.CNT_W(10)) u_rdiv (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clear    (hold),
    .tick     (ref_tick),
    .ratio    (rdiv_ratio[9:0]),
    .pulse_ff (rdiv_pulse)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      half_tgl_ff <= 1'b0;
    end else if (hold) begin
      half_tgl_ff <= 1'b0;
    end else if (rdiv_pulse) begin
      half_tgl_ff <= ~half_tgl_ff;
    end
  end

  assign ref_pfd = rdiv_pulse & (~half_eff_ff | half_tgl_ff);

  // ----------------------------------------------------------------
  // fractional feedback path
  // ----------------------------------------------------------------
  logic        fb_tick;
  logic        n_pulse;
  logic        carry_ff;
  logic [11:0] num_acc_ff;
  logic [11:0] den_cnt_ff;
  logic [12:0] nxt_sum;
  logic        nxt_carry;
  logic        mod_ok;

  assign fb_tick   = fb_q & ~fb_d_ff;
  assign mod_ok    = mod_eff_ff >= MOD_MIN;
  assign nxt_sum   = {1'b0, num_acc_ff} + {1'b0, partial_numerator_val};
  assign nxt_carry = mod_ok && (nxt_sum >= {1'b0, mod_eff_ff});

  ssl_pulse_div #(.CNT_W(17)) u_ndiv (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clear    (hold),
    .tick     (fb_tick),
    .ratio    (ssl_safe_ratio({1'b0, int_val} + {16'h0000, carry_ff})),
    .pulse_ff (n_pulse)
  );

  // numerator accumulates; denominator counter restarts the sequence
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      num_acc_ff <= 12'h000;
      den_cnt_ff <= 12'h000;
      carry_ff   <= 1'b0;
    end else if (hold || !mod_ok) begin
      num_acc_ff <= 12'h000;
      den_cnt_ff <= 12'h000;
      carry_ff   <= 1'b0;
    end else if (n_pulse) begin
      carry_ff <= nxt_carry;
      if (den_cnt_ff >= mod_eff_ff - 12'h001) begin
        den_cnt_ff <= 12'h000;
        num_acc_ff <= 12'h000;
      end else begin
        den_cnt_ff <= den_cnt_ff + 12'h001;
        num_acc_ff <= nxt_carry ? 12'(nxt_sum - {1'b0, mod_eff_ff}) : nxt_sum[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // digital lock detector
  // ----------------------------------------------------------------
  ssl_lock_t   lock_st_ff;
  ssl_lock_t   nxt_lock_st;
  logic [7:0]  gap_ff;
  logic [7:0]  good_ff;
  logic        fb_seen_ff;
  logic        bad_evt;

  assign bad_evt = hold | (ref_pfd & ~fb_seen_ff & ~n_pulse) | (n_pulse & (gap_ff > 8'(LOCK_WIN)));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap_ff     <= 8'hFF;
      fb_seen_ff <= 1'b0;
    end else begin
      if (ref_pfd) begin
        gap_ff <= 8'h00;
      end else if (gap_ff != 8'hFF) begin
        gap_ff <= gap_ff + 8'h01;
      end
      if (n_pulse) begin
        fb_seen_ff <= 1'b1;
      end else if (ref_pfd) begin
        fb_seen_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      good_ff <= 8'h00;
    end else if (bad_evt) begin
      good_ff <= 8'h00;
    end else if (n_pulse && good_ff != 8'hFF) begin
      good_ff <= good_ff + 8'h01;
    end
  end

  always_comb begin
    nxt_lock_st = lock_st_ff;
    if (bad_evt) begin
      nxt_lock_st = LK_UNLOCKED;
    end else if (good_ff >= 8'(LOCK_GOOD)) begin
      nxt_lock_st = LK_LOCKED;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_st_ff <= LK_UNLOCKED;
    end else begin
      lock_st_ff <= nxt_lock_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic        locked;
  logic        presc89;
  logic [2:0]  probe_sel;

  assign locked    = lock_st_ff == LK_LOCKED;
  assign presc89   = latch_ff[SEL_R1][PRESC_BIT];
  assign probe_sel = latch_ff[SEL_R2][PROBE_LSB +: 3];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_indicator        <= 1'b0;
      internal_probe_output <= 1'b0;
    end else begin
      lock_indicator <= locked;
      unique case (probe_sel)
        PROBE_HIGH: internal_probe_output <= 1'b1;
        PROBE_RDIV: internal_probe_output <= ref_pfd;
        PROBE_NDIV: internal_probe_output <= n_pulse;
        PROBE_LOCK: internal_probe_output <= locked;
        default:    internal_probe_output <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rf_out_enable  <= 1'b0;
      cp_tristate    <= 1'b1;
      device_powered <= 1'b0;
    end else begin
      device_powered <= ce_q & ~latch_ff[SEL_R2][PD_BIT];
      cp_tristate    <= ~ce_q | latch_ff[SEL_R2][PD_BIT] | latch_ff[SEL_R2][CPTRI_BIT];
      rf_out_enable  <= ce_q & mute_n_q & latch_ff[SEL_R4][RFEN_BIT]
                        & (~latch_ff[SEL_R4][MUTE_UNTIL_LOCK_BIT] | locked);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      integer_mode  <= 1'b0;
      cfg_range_err <= 1'b0;
    end else begin
      integer_mode  <= (partial_numerator_val == 12'h000) && latch_ff[SEL_R2][LDF_BIT];
      cfg_range_err <= (presc89 ? (int_val < INT_MIN_89) : (int_val < INT_MIN_45 || int_val > INT_MAX_45))
                       || !mod_ok || (partial_numerator_val >= mod_eff_ff) || (rdiv_eff_ff == 10'h000);
    end
  end

  assign rf_power_level = latch_ff[SEL_R4][PWR_LSB +: 2];
  assign out_div_sel    = div_sel_ff;
  assign cp_current     = cp_eff_ff;
  assign phase_value    = phase_eff_ff;
  assign prescaler_89   = presc89;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_shift;
    sclk_rise |=> shift_ff == {$past(shift_ff[30:0]), $past(sdat_q)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift register did not take bit");

  property p_load0;
    le_rise && shift_ff[2:0] == SEL_R0 |=> latch_ff[0] == $past(shift_ff);
  endproperty
  a_load0: assert property (p_load0) else $error("latch zero not loaded");

  property p_badsel;
    le_rise && shift_ff[2:0] > 3'h5 |=> $stable(latch_ff[0]) && $stable(latch_ff[4]) && $stable(latch_ff[5]);
  endproperty
  a_badsel: assert property (p_badsel) else $error("unused code changed a latch");

  property p_shadow_hold;
    !r0_wr |=> $stable(mod_eff_ff) && $stable(rdiv_eff_ff) && $stable(cp_eff_ff);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("shadow changed without latch zero");

  property p_shadow_apply;
    r0_wr |=> mod_eff_ff == $past(latch_ff[1][MOD_LSB +: 12]) && rdiv_eff_ff == $past(latch_ff[2][RDIV_LSB +: 10]);
  endproperty
  a_shadow_apply: assert property (p_shadow_apply) else $error("latch zero did not apply shadow");

  property p_divsel;
    wr[SEL_R4] && !dbuf_on |=> out_div_sel == $past(shift_ff[DIVSEL_LSB +: 3]);
  endproperty
  a_divsel: assert property (p_divsel) else $error("divider select not direct");

  property p_probe_lock;
    probe_sel == PROBE_LOCK ##1 probe_sel == PROBE_LOCK |-> internal_probe_output == lock_indicator;
  endproperty
  a_probe_lock: assert property (p_probe_lock) else $error("probe does not show lock");

  property p_mute_until_lock;
    latch_ff[4][MUTE_UNTIL_LOCK_BIT] && !locked |=> !rf_out_enable;
  endproperty
  a_mute_until_lock: assert property (p_mute_until_lock) else $error("output on before lock");

  property p_ce;
    !ce_q |=> cp_tristate && !device_powered;
  endproperty
  a_ce: assert property (p_ce) else $error("chip enable low did not power down");

  property p_lockout;
    bad_evt |=> ##1 !lock_indicator;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lock indicator stayed high");

  property p_mute;
    !mute_n_q |=> !rf_out_enable;
  endproperty
  a_mute: assert property (p_mute) else $error("mute pin did not silence output");
endmodule

//--- tb/ssl_host_model.sv
`timescale 1ns/1ps
module ssl_host_model (
  input  wire logic core_clk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      load_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // ----------------------------------------
  // word transfer, called just after a falling edge
  // ----------------------------------------
  task automatic send(input logic [31:0] w, input int half);
    for (int i = 31; i >= 0; i--) begin
      serial_data = w[i];
      repeat (half) @(negedge core_clk);
      serial_clk = 1'b1;
      repeat (half) @(negedge core_clk);
      serial_clk = 1'b0;
    end
    // data line no longer held: show the inverse of the last bit
    serial_data = ~w[0];
    load_strobe = 1'b1;
    repeat (half) @(negedge core_clk);
    load_strobe = 1'b0;
    repeat (half + 2) @(negedge core_clk);
  endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import ssl_pkg::*;
  typedef struct {
    logic [31:0] w;
    logic [1:0]  pwr;
    logic        presc;
    logic [2:0]  div;
    logic        rfen;
  } ssl_row_t;

  logic        core_clk = 1'b0;
  logic        rstn;
  logic        serial_clk;
  logic        serial_data;
  logic        load_strobe;
  logic        chip_enable;
  logic        rf_output_mute_n;
  logic        ref_in = 1'b0;
  logic        rf_fb_in = 1'b0;
  logic        fb_on = 1'b0;
  logic        lock_indicator;
  logic        internal_probe_output;
  logic        rf_out_enable;
  logic [1:0]  rf_power_level;
  logic [2:0]  out_div_sel;
  logic [2:0]  cp_current;
  logic [11:0] phase_value;
  logic        prescaler_89;
  logic        cp_tristate;
  logic        device_powered;
  logic        integer_mode;
  logic        cfg_range_err;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  // ----------------------------------------
  // ordinary writes: word, then power, prescaler, divider, enable
  // ----------------------------------------
  ssl_row_t rows [7] = '{
    '{32'h0030_0034, 2'h2, 1'b0, 3'h3, 1'b1},
    '{32'h0050_0004, 2'h0, 1'b0, 3'h5, 1'b0},
    '{32'h0010_003C, 2'h3, 1'b0, 3'h1, 1'b1},
    '{32'h0000_002C, 2'h1, 1'b0, 3'h0, 1'b1},
    '{32'h0800_0001, 2'h1, 1'b1, 3'h0, 1'b1},
    '{32'h0000_001E, 2'h1, 1'b1, 3'h0, 1'b1},
    '{32'h0070_001F, 2'h1, 1'b1, 3'h0, 1'b1}
  };

  always #20 core_clk = ~core_clk;
  // reference toggles every five cycles; feedback, when on, trails it by one cycle
  always @(negedge core_clk) begin
    if (cycles % 5 == 0) begin
      ref_in <= ~ref_in;
    end
    rf_fb_in <= fb_on & ref_in;
  end

  ssl_host_model i_host (
    .core_clk    (core_clk),
    .serial_clk  (serial_clk),
    .serial_data (serial_data),
    .load_strobe (load_strobe)
  );

  ssl_config_top i_dut (
    .core_clk              (core_clk),
    .rstn                  (rstn),
    .serial_clk            (serial_clk),
    .serial_data           (serial_data),
    .load_strobe           (load_strobe),
    .chip_enable           (chip_enable),
    .rf_output_mute_n      (rf_output_mute_n),
    .ref_in                (ref_in),
    .rf_fb_in              (rf_fb_in),
    .lock_indicator        (lock_indicator),
    .internal_probe_output (internal_probe_output),
    .rf_out_enable         (rf_out_enable),
    .rf_power_level        (rf_power_level),
    .out_div_sel           (out_div_sel),
    .cp_current            (cp_current),
    .phase_value           (phase_value),
    .prescaler_89          (prescaler_89),
    .cp_tristate           (cp_tristate),
    .device_powered        (device_powered),
    .integer_mode          (integer_mode),
    .cfg_range_err         (cfg_range_err)
  );

  // ----------------------------------------
  // compare and closing
  // ----------------------------------------
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] w);
    i_host.send(w, 3);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    chip_enable = 1'b1;
    rf_output_mute_n = 1'b1;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("range error", 12'h001, 12'(cfg_range_err));
    foreach (rows[i]) begin
      wr(rows[i].w);
      chk("power", 12'(rows[i].pwr), 12'(rf_power_level));
      chk("prescaler", 12'(rows[i].presc), 12'(prescaler_89));
      chk("divider", 12'(rows[i].div), 12'(out_div_sel));
      chk("rf enable", 12'(rows[i].rfen), 12'(rf_out_enable));
    end
    // shadowed settings wait for a latch zero write, slow host here
    i_host.send(32'h0D5E_0029, 5);
    chk("phase", 12'h000, phase_value);
    wr(32'h0000_4A02);
    chk("pump current", 12'h000, 12'(cp_current));
    wr(32'h0032_0000);
    chk("phase", 12'hABC, phase_value);
    chk("pump current", 12'h005, 12'(cp_current));
    chk("range error", 12'h000, 12'(cfg_range_err));
    chk("integer mode", 12'h000, 12'(integer_mode));
    wr(32'h0000_6B02);
    chk("integer mode", 12'h001, 12'(integer_mode));
    wr(32'h0060_002C);
    chk("divider", 12'h000, 12'(out_div_sel));
    wr(32'h0032_0000);
    chk("divider", 12'h006, 12'(out_div_sel));
    // whole part and fraction boundaries with the 8/9 prescaler
    wr(32'h0025_0000);
    chk("range error", 12'h001, 12'(cfg_range_err));
    wr(32'h0025_8000);
    chk("range error", 12'h000, 12'(cfg_range_err));
    wr(32'h0025_8028);
    chk("range error", 12'h001, 12'(cfg_range_err));
    wr(32'h0025_8020);
    chk("range error", 12'h000, 12'(cfg_range_err));
    chk("integer mode", 12'h000, 12'(integer_mode));
    wr(32'h0400_6B02);
    chk("probe", 12'h001, 12'(internal_probe_output));
    wr(32'h1800_6B02);
    chk("probe", 12'h000, 12'(internal_probe_output));
    chk("lock", 12'h000, 12'(lock_indicator));
    // feedback never toggles, so mute-until-lock keeps the stage off
    wr(32'h0060_042C);
    chk("rf enable", 12'h000, 12'(rf_out_enable));
    wr(32'h0060_002C);
    chk("rf enable", 12'h001, 12'(rf_out_enable));
    rf_output_mute_n = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("rf enable", 12'h000, 12'(rf_out_enable));
    rf_output_mute_n = 1'b1;
    chip_enable = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("powered", 12'h000, 12'(device_powered));
    chk("pump off", 12'h001, 12'(cp_tristate));
    chip_enable = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("powered", 12'h001, 12'(device_powered));
    chk("pump off", 12'h000, 12'(cp_tristate));
    chk("rf enable", 12'h001, 12'(rf_out_enable));
    // whole part one with trailing feedback locks the loop
    fb_on = 1'b1;
    wr(32'h0000_8000);
    repeat (100) @(negedge core_clk);
    chk("lock", 12'h001, 12'(lock_indicator));
    chk("probe", 12'h001, 12'(internal_probe_output));
    wr(32'h0060_042C);
    chk("rf enable", 12'h001, 12'(rf_out_enable));
    fb_on = 1'b0;
    repeat (40) @(negedge core_clk);
    chk("lock", 12'h000, 12'(lock_indicator));
    chk("rf enable", 12'h000, 12'(rf_out_enable));
    // second reset in mid-run clears the latches
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("power", 12'h000, 12'(rf_power_level));
    chk("phase", 12'h000, phase_value);
    chk("pump off", 12'h001, 12'(cp_tristate));
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    stop_test();
  end
endmodule
